// ### verilog/psm_defines.svh
// Offsets, fields, reset values and counts of the power save controller
// Function
// - Power-save request enters sleep or idle per operand
// - Sleep stops system clock and on-chip oscillators
// - Clock failure monitor inactive throughout sleep
// - Sleep keeps low power RC running with watchdog
// - Low-voltage and brownout detectors stay active in sleep
// - Watchdog count cleared before entering sleep
// - Sleep disables every system-clocked peripheral
// - Sleep exits on enabled interrupt, reset, watchdog
// - Idle halts CPU, clears watchdog, keeps clock
// - Idle peripherals run unless their halt bit set
// - Idle keeps RC clock for watchdog or monitor
// - Idle exits on enabled interrupt, reset, watchdog
// - Idle wake restores CPU clock, resumes at once
// - Low-voltage flag set when selected tap below reference
// - Trip point from sixteen taps or external input
// - Clock source from config bits, then software switchable
// - Oscillator control register switches, reports clock status
// - Crystal wake from sleep waits 1024 oscillator cycles
// - Watchdog timeout resets, except wakes in sleep
`ifndef PSM_DEFINES_SVH
`define PSM_DEFINES_SVH

// Register byte offsets
`define PSM_CTRL_OFS    8'h00
`define PSM_OSC_OFS     8'h04
`define PSM_IRQEN_OFS   8'h08
`define PSM_HALT_OFS    8'h0c
`define PSM_STAT_OFS    8'h10

// Control register fields
`define PSM_CTRL_WDT    0
`define PSM_CTRL_CLOCK_FAILURE_MONITOR   1
`define PSM_CTRL_LVD    2
`define PSM_CTRL_BOR    3
`define PSM_CTRL_LVDEXT 4
`define PSM_CTRL_TAP_LO 8
`define PSM_CTRL_TAP_HI 11

// Oscillator control register fields
`define PSM_OSC_CUR_LO  0
`define PSM_OSC_CUR_HI  2
`define PSM_OSC_NEW_LO  4
`define PSM_OSC_NEW_HI  6
`define PSM_OSC_SWITCH  8
`define PSM_OSC_OSTBSY  9

// Status register fields
`define PSM_STAT_LVDF   0
`define PSM_STAT_WDTWK  1
`define PSM_STAT_MODELO 2
`define PSM_STAT_MODEHI 3
`define PSM_STAT_CLRWDT 4

// Reset values and counts
`define PSM_CTRL_RST    12'h000
`define PSM_MASK_RST    8'h00
`define PSM_NUM_SRC     3'h5
`define PSM_OST_COUNT   10'h3ff
`define PSM_WDT_TIMEOUT 16384

`endif

// ### verilog/psm_pkg.sv
// Types shared by the power save controller modules
package psm_pkg;

  // Controller modes
  typedef enum logic [1:0] {
    ST_RUN,
    ST_IDLE,
    ST_SLEEP,
    ST_START
  } mode_e;

  // System clock sources, in oscillator control register order
  typedef enum logic [2:0] {
    SRC_FRC,
    SRC_LOW_POWER_RC_CLOCK,
    SRC_PRIMARY_XTAL,
    SRC_SECONDARY_XTAL,
    SRC_EXTERNAL
  } clk_src_e;

endpackage : psm_pkg

// ### verilog/psm_ost_if.sv
// Carrier between the controller and the oscillator startup timer
`timescale 1ns/100ps
`default_nettype none

interface psm_ost_if;
  logic start;
  logic tick;
  logic done;

  modport ctrl  (output start, output tick, input done);
  modport timer (input start, input tick, output done);
endinterface : psm_ost_if

`default_nettype wire

// ### verilog/oscillator_startup_timer.sv
// Counts oscillator cycles after a crystal restart
`timescale 1ns/100ps
`default_nettype none
`include "psm_defines.svh"

module oscillator_startup_timer (
  // System
  input wire logic clk,
  input wire logic rst,
  // Controller side
  psm_ost_if.timer ost
);

  logic       busy_q;
  logic [9:0] cnt_q;

  // Count exactly 1024 oscillator ticks from start to done
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_q <= 1'b0;
      cnt_q  <= 10'h000;
      ost.done <= 1'b0;
    end else begin
      ost.done <= 1'b0;
      if (ost.start) begin
        busy_q <= 1'b1;
        cnt_q  <= 10'h000;
      end else if (busy_q && ost.tick) begin
        if (cnt_q == `PSM_OST_COUNT) begin
          busy_q   <= 1'b0;
          ost.done <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 10'h001;
        end
      end
    end
  end

endmodule : oscillator_startup_timer

`default_nettype wire

// ### verilog/power_save_mode_controller.sv
// Power save mode, clock source and low-voltage controller
`timescale 1ns/100ps
`default_nettype none
`include "psm_defines.svh"

module power_save_mode_controller #(
  parameter int WDT_TIMEOUT_CYCLES = `PSM_WDT_TIMEOUT
) (
  // System
  input  wire logic        clk,
  input  wire logic        rst,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // CPU core
  input  wire logic        power_save_instruction,
  input  wire logic        power_save_sleep,
  output logic             cpu_run,
  output logic             cpu_resume,
  output logic             cpu_vector,
  // Interrupt sources
  input  wire logic [7:0]  irq_in,
  // Pins and analog comparators
  input  wire logic [2:0]  cfg_clk_src,
  input  wire logic [15:0] lvd_tap_below,
  input  wire logic        external_trip_input,
  input  wire logic        osc_tick,
  // Clock and monitor enables
  output logic             sys_clk_en,
  output logic      [4:0]  osc_en,
  output logic             low_power_rc_clock,
  output logic             clock_failure_monitor,
  output logic             low_voltage_detector,
  output logic             brownout_reset,
  output logic      [7:0]  periph_clk_en,
  // Status
  output logic             lvd_flag,
  output logic             wdt_reset_req
);

  psm_ost_if ost_bus ();

  psm_pkg::mode_e    state_q;
  psm_pkg::mode_e    state_d;
  psm_pkg::clk_src_e cur_src_q;
  logic [2:0]        new_src_q;
  logic [11:0]       ctrl_q;
  logic [7:0]        irq_en_q;
  logic [7:0]        halt_idle_q;
  logic              wdt_wake_q;
  logic              cfg_loaded_q;
  logic [31:0]       wdt_cnt_q;
  logic              wdt_timeout;
  logic              wdt_clear;
  logic              irq_wake;
  logic              wake;
  logic              xtal_src;
  logic              accept;
  logic              wr_lo;
  logic              wr_hi;
  logic              lvd_trip;
  logic [2:0]        cfg_s1_q;
  logic [2:0]        cfg_s2_q;
  logic [16:0]       lvd_s1_q;
  logic [16:0]       lvd_s2_q;
  logic              tick_s1_q;
  logic              tick_s2_q;
  logic              tick_s3_q;

  // Config pins keep sampling through reset, so the first load after
  // release sees the real selection and not a cleared stage
  always_ff @(posedge clk) begin
    cfg_s1_q <= cfg_clk_src;
    cfg_s2_q <= cfg_s1_q;
  end

  // Two-stage synchronisers on pins and comparator outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      lvd_s1_q  <= 17'h00000;
      lvd_s2_q  <= 17'h00000;
      tick_s1_q <= 1'b0;
      tick_s2_q <= 1'b0;
      tick_s3_q <= 1'b0;
    end else begin
      lvd_s1_q  <= {external_trip_input, lvd_tap_below};
      lvd_s2_q  <= lvd_s1_q;
      tick_s1_q <= osc_tick;
      tick_s2_q <= tick_s1_q;
      tick_s3_q <= tick_s2_q;
    end
  end

  // Rising edge of the synchronised oscillator tick feeds the timer
  assign ost_bus.tick = tick_s2_q & ~tick_s3_q;

  oscillator_startup_timer u_ost (
    .clk (clk),
    .rst (rst),
    .ost (ost_bus.timer)
  );

  // Bus decode; ack answers one cycle after the strobe
  assign accept = cyc_i & stb_i & ~ack_o;
  assign wr_lo  = accept & we_i & sel_i[0];
  assign wr_hi  = accept & we_i & sel_i[1];

  // Trip point from one of sixteen taps or the external input
  always_comb begin
    if (ctrl_q[`PSM_CTRL_LVDEXT]) begin
      lvd_trip = lvd_s2_q[16];
    end else begin
      lvd_trip = lvd_s2_q[ctrl_q[`PSM_CTRL_TAP_HI:`PSM_CTRL_TAP_LO]];
    end
  end

  // Wake sources and clock type
  assign irq_wake = |(irq_in & irq_en_q);
  assign wake     = irq_wake | wdt_timeout;
  assign xtal_src = (cur_src_q == psm_pkg::SRC_PRIMARY_XTAL) ||
                    (cur_src_q == psm_pkg::SRC_SECONDARY_XTAL);

  // Mode sequencing
  always_comb begin
    state_d       = state_q;
    ost_bus.start = 1'b0;
    unique case (state_q)
      psm_pkg::ST_RUN: begin
        if (power_save_instruction) begin
          state_d = power_save_sleep ? psm_pkg::ST_SLEEP
                                     : psm_pkg::ST_IDLE;
        end
      end
      psm_pkg::ST_IDLE: begin
        if (wake) begin
          state_d = psm_pkg::ST_RUN;
        end
      end
      psm_pkg::ST_SLEEP: begin
        if (wake && xtal_src) begin
          state_d       = psm_pkg::ST_START;
          ost_bus.start = 1'b1;
        end else if (wake) begin
          state_d = psm_pkg::ST_RUN;
        end
      end
      psm_pkg::ST_START: begin
        if (ost_bus.done) begin
          state_d = psm_pkg::ST_RUN;
        end
      end
    endcase
  end

  // Mode register; any device reset returns to run
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= psm_pkg::ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // Watchdog clear on entry to either save mode or by software
  assign wdt_clear = (state_q == psm_pkg::ST_RUN) &&
                     power_save_instruction;
  assign wdt_timeout = ctrl_q[`PSM_CTRL_WDT] &&
                       (wdt_cnt_q == 32'(WDT_TIMEOUT_CYCLES - 1));

  // Watchdog counter runs from the RC clock in every mode
  always_ff @(posedge clk) begin
    if (rst) begin
      wdt_cnt_q <= 32'h0000_0000;
    end else if (!ctrl_q[`PSM_CTRL_WDT] || wdt_clear || wdt_timeout) begin
      wdt_cnt_q <= 32'h0000_0000;
    end else if (wr_lo && adr_i == `PSM_STAT_OFS &&
                 dat_i[`PSM_STAT_CLRWDT]) begin
      wdt_cnt_q <= 32'h0000_0000;
    end else begin
      wdt_cnt_q <= wdt_cnt_q + 32'h0000_0001;
    end
  end

  // Timeout resets the device, except in sleep where it only wakes
  always_ff @(posedge clk) begin
    if (rst) begin
      wdt_reset_req <= 1'b0;
    end else begin
      wdt_reset_req <= wdt_timeout &&
                       (state_q != psm_pkg::ST_SLEEP);
    end
  end

  // Sticky wake-by-watchdog status; a new event beats the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      wdt_wake_q <= 1'b0;
    end else if (wdt_timeout && state_q == psm_pkg::ST_SLEEP) begin
      wdt_wake_q <= 1'b1;
    end else if (wr_lo && adr_i == `PSM_STAT_OFS &&
                 dat_i[`PSM_STAT_WDTWK]) begin
      wdt_wake_q <= 1'b0;
    end
  end

  // Low-voltage flag; the detector keeps running in sleep
  always_ff @(posedge clk) begin
    if (rst) begin
      lvd_flag <= 1'b0;
    end else if (ctrl_q[`PSM_CTRL_LVD] && lvd_trip) begin
      lvd_flag <= 1'b1;
    end else if (wr_lo && adr_i == `PSM_STAT_OFS &&
                 dat_i[`PSM_STAT_LVDF]) begin
      lvd_flag <= 1'b0;
    end
  end

  // Control, interrupt enable and halt-in-idle registers
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q      <= `PSM_CTRL_RST;
      irq_en_q    <= `PSM_MASK_RST;
      halt_idle_q <= `PSM_MASK_RST;
    end else begin
      if (wr_lo && adr_i == `PSM_CTRL_OFS) begin
        ctrl_q[7:0] <= dat_i[7:0];
      end
      if (wr_hi && adr_i == `PSM_CTRL_OFS) begin
        ctrl_q[11:8] <= dat_i[11:8];
      end
      if (wr_lo && adr_i == `PSM_IRQEN_OFS) begin
        irq_en_q <= dat_i[7:0];
      end
      if (wr_lo && adr_i == `PSM_HALT_OFS) begin
        halt_idle_q <= dat_i[7:0];
      end
    end
  end

  // Clock source: taken from config bits after reset, then switched
  // by software. Switching is refused outside run so a sleeping
  // oscillator is never chosen behind the sequencer's back.
  always_ff @(posedge clk) begin
    if (rst) begin
      cur_src_q    <= psm_pkg::SRC_FRC;
      new_src_q    <= 3'h0;
      cfg_loaded_q <= 1'b0;
    end else if (!cfg_loaded_q) begin
      cfg_loaded_q <= 1'b1;
      if (cfg_s2_q < `PSM_NUM_SRC) begin
        cur_src_q <= psm_pkg::clk_src_e'(cfg_s2_q);
      end
      new_src_q <= cfg_s2_q;
    end else begin
      if (wr_lo && adr_i == `PSM_OSC_OFS) begin
        new_src_q <= dat_i[`PSM_OSC_NEW_HI:`PSM_OSC_NEW_LO];
      end
      if (wr_hi && adr_i == `PSM_OSC_OFS && dat_i[`PSM_OSC_SWITCH] &&
          state_q == psm_pkg::ST_RUN && new_src_q < `PSM_NUM_SRC) begin
        cur_src_q <= psm_pkg::clk_src_e'(new_src_q);
      end
    end
  end

  // Clock, oscillator and monitor enables follow the next mode
  always_ff @(posedge clk) begin
    if (rst) begin
      cpu_run               <= 1'b1;
      sys_clk_en            <= 1'b1;
      osc_en                <= 5'h00;
      low_power_rc_clock    <= 1'b0;
      clock_failure_monitor <= 1'b0;
      low_voltage_detector  <= 1'b0;
      brownout_reset        <= 1'b0;
    end else begin
      cpu_run    <= (state_d == psm_pkg::ST_RUN);
      sys_clk_en <= (state_d == psm_pkg::ST_RUN) ||
                    (state_d == psm_pkg::ST_IDLE);
      // Oscillator restarts during the startup wait so it can settle
      osc_en <= (state_d == psm_pkg::ST_SLEEP) ? 5'h00
              : 5'(5'h01 << cur_src_q);
      clock_failure_monitor <= ctrl_q[`PSM_CTRL_CLOCK_FAILURE_MONITOR] &&
                               (state_d == psm_pkg::ST_RUN ||
                                state_d == psm_pkg::ST_IDLE);
      low_power_rc_clock <= ctrl_q[`PSM_CTRL_WDT] ||
                            (ctrl_q[`PSM_CTRL_CLOCK_FAILURE_MONITOR] &&
                             state_d != psm_pkg::ST_SLEEP);
      low_voltage_detector <= ctrl_q[`PSM_CTRL_LVD];
      brownout_reset       <= ctrl_q[`PSM_CTRL_BOR];
    end
  end

  // Per peripheral clock gate: off in sleep, halt bit in idle
  for (genvar i = 0; i < 8; i++) begin : g_periph
    always_ff @(posedge clk) begin
      if (rst) begin
        periph_clk_en[i] <= 1'b1;
      end else begin
        unique case (state_d)
          psm_pkg::ST_RUN:   periph_clk_en[i] <= 1'b1;
          psm_pkg::ST_IDLE:  periph_clk_en[i] <= ~halt_idle_q[i];
          psm_pkg::ST_SLEEP: periph_clk_en[i] <= 1'b0;
          psm_pkg::ST_START: periph_clk_en[i] <= 1'b0;
        endcase
      end
    end
  end

  // Resume pulse on return to run; vector when an interrupt woke it
  always_ff @(posedge clk) begin
    if (rst) begin
      cpu_resume <= 1'b0;
      cpu_vector <= 1'b0;
    end else begin
      cpu_resume <= (state_q != psm_pkg::ST_RUN) &&
                    (state_d == psm_pkg::ST_RUN);
      if (state_q != psm_pkg::ST_RUN && state_q != psm_pkg::ST_START &&
          wake) begin
        cpu_vector <= irq_wake;
      end
    end
  end

  // Read data and ack; unmapped offsets read zero and still ack
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= accept;
      dat_o <= 32'h0000_0000;
      if (accept && !we_i) begin
        unique case (adr_i)
          `PSM_CTRL_OFS:  dat_o[11:0] <= ctrl_q;
          `PSM_OSC_OFS: begin
            dat_o[`PSM_OSC_CUR_HI:`PSM_OSC_CUR_LO] <= cur_src_q;
            dat_o[`PSM_OSC_NEW_HI:`PSM_OSC_NEW_LO] <= new_src_q;
            dat_o[`PSM_OSC_OSTBSY] <= (state_q == psm_pkg::ST_START);
          end
          `PSM_IRQEN_OFS: dat_o[7:0] <= irq_en_q;
          `PSM_HALT_OFS:  dat_o[7:0] <= halt_idle_q;
          `PSM_STAT_OFS: begin
            dat_o[`PSM_STAT_LVDF]  <= lvd_flag;
            dat_o[`PSM_STAT_WDTWK] <= wdt_wake_q;
            dat_o[`PSM_STAT_MODEHI:`PSM_STAT_MODELO] <= state_q;
          end
          default:        dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule : power_save_mode_controller

`default_nettype wire

// ### tb/psm_chk.sv
// Port checker for the power save controller
`timescale 1ns/100ps
`default_nettype none

module psm_chk (
  // System
  input wire logic       clk,
  input wire logic       rst,
  // CPU side
  input wire logic       power_save_instruction,
  input wire logic       power_save_sleep,
  input wire logic       cpu_run,
  input wire logic       cpu_resume,
  // Clock and peripheral enables
  input wire logic       sys_clk_en,
  input wire logic [4:0] osc_en,
  input wire logic       clock_failure_monitor,
  input wire logic [7:0] periph_clk_en,
  input wire logic       wdt_reset_req
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_save_leaves_run: assert property (
    cpu_run && power_save_instruction |=> !cpu_run)
    else $error("save request left the cpu running");
  a_sleep_stops_clk: assert property (
    cpu_run && power_save_instruction && power_save_sleep
      |=> !sys_clk_en && osc_en == 5'h00)
    else $error("clock source still on in sleep");
  a_idle_keeps_clk: assert property (
    cpu_run && power_save_instruction && !power_save_sleep
      |=> sys_clk_en && !cpu_run)
    else $error("idle entry wrong");
  a_monitor_off: assert property (
    !sys_clk_en |-> !clock_failure_monitor)
    else $error("clock monitor active without clock");
  a_sleep_periph_off: assert property (
    !sys_clk_en |-> periph_clk_en == 8'h00 && !cpu_run)
    else $error("peripheral or cpu clocked in sleep");
  a_run_periph_on: assert property (
    cpu_run |-> periph_clk_en == 8'hff)
    else $error("peripheral gated while running");
  a_wake_resumes: assert property (
    $rose(cpu_run) |-> cpu_resume)
    else $error("run re-entered without resume");
  a_resume_pulse: assert property (
    cpu_resume |-> cpu_run ##1 !cpu_resume)
    else $error("resume not a single pulse in run");
  a_wdt_not_sleep: assert property (
    wdt_reset_req |-> ($past(osc_en) != 5'h00) ##1 !wdt_reset_req)
    else $error("watchdog reset in sleep or too long");
endmodule : psm_chk

bind power_save_mode_controller psm_chk u_chk (
  .clk(clk),
  .rst(rst),
  .power_save_instruction(power_save_instruction),
  .power_save_sleep(power_save_sleep),
  .cpu_run(cpu_run),
  .cpu_resume(cpu_resume),
  .sys_clk_en(sys_clk_en),
  .osc_en(osc_en),
  .clock_failure_monitor(clock_failure_monitor),
  .periph_clk_en(periph_clk_en),
  .wdt_reset_req(wdt_reset_req)
);

`default_nettype wire

// ### tb/cpu_model.sv
// Behavioural CPU core, interrupt sources and crystal
`timescale 1ns/100ps
`default_nettype none

module cpu_model (
  // System
  input  wire logic       clk,
  // Toward the controller
  output logic            power_save_instruction,
  output logic            power_save_sleep,
  output logic      [7:0] irq_in,
  output logic            osc_tick,
  // From the controller
  input  wire logic [4:0] osc_en
);
  logic [1:0] div_q = 2'h0;

  // Idle outputs at time zero
  initial begin
    power_save_instruction = 1'b0;
    power_save_sleep       = 1'b0;
    irq_in                 = 8'h00;
  end

  // Crystal swings only while enabled, a quarter of clk
  always @(posedge clk) begin
    if (|osc_en) div_q <= div_q + 2'h1;
  end
  assign osc_tick = div_q[1];

  // One-cycle request; operand is not held afterwards
  task automatic save(input logic sleep);
    power_save_instruction <= 1'b1;
    power_save_sleep       <= sleep;
    @(posedge clk);
    power_save_instruction <= 1'b0;
    power_save_sleep       <= ~sleep;
  endtask : save

  // Level interrupt requests
  task automatic raise(input logic [7:0] v);
    irq_in <= v;
  endtask : raise
endmodule : cpu_model

`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the power save controller
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  localparam int WDT = 64;
  logic        clk, rst, cyc_i, stb_i, we_i, ack_o, cpu_run;
  logic        cpu_resume, cpu_vector, power_save_instruction;
  logic        power_save_sleep, external_trip_input, osc_tick;
  logic        sys_clk_en, low_power_rc_clock, clock_failure_monitor;
  logic        low_voltage_detector, brownout_reset, lvd_flag;
  logic        wdt_reset_req;
  logic [7:0]  adr_i, irq_in, periph_clk_en, h;
  logic [3:0]  sel_i, t;
  logic [31:0] dat_i, dat_o, q;
  logic [2:0]  cfg_clk_src, cur;
  logic [4:0]  osc_en;
  logic [15:0] lvd_tap_below;
  int          n_mismatch, checked, cycles, n;

  power_save_mode_controller #(.WDT_TIMEOUT_CYCLES(WDT)) u_dut (
    .clk, .rst, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .power_save_instruction, .power_save_sleep, .cpu_run,
    .cpu_resume, .cpu_vector, .irq_in, .cfg_clk_src, .lvd_tap_below,
    .external_trip_input, .osc_tick, .sys_clk_en, .osc_en,
    .low_power_rc_clock, .clock_failure_monitor, .low_voltage_detector,
    .brownout_reset, .periph_clk_en, .lvd_flag, .wdt_reset_req);
  cpu_model u_cpu (.clk, .power_save_instruction, .power_save_sleep,
    .irq_in, .osc_tick, .osc_en);

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard, well above the crystal wait
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end

  function automatic logic [4:0] hot(input logic [2:0] s);
    return 5'h01 << s;
  endfunction : hot

  // Classic cycle, held until ack is sampled high
  // Only the hang guard ends a wait for ack
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r,
                    input logic [3:0] s = 4'h3);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= d;
    do begin
      @(posedge clk);
    end while (ack_o !== 1'b1);
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk);
  endtask : wb

  task automatic chk(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Cycles until the resume pulse, bounded
  task automatic wake(output int c);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (cpu_resume !== 1'b1 && c < 6000);
  endtask : wake

  task automatic end_sim();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  // Reset, then the scenarios in order
  initial begin
    void'($urandom(42));
    cfg_clk_src = 3'($urandom % 5);
    rst = 1'b1;
    {cyc_i, stb_i, we_i, external_trip_input} = 4'h0;
    adr_i = 8'h00;
    dat_i = 32'h0;
    sel_i = 4'h3;
    lvd_tap_below = 16'h0000;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    wb(1'b0, 8'h04, 32'h0, q);
    chk("osc_cur", 32'(cfg_clk_src), 32'(q[2:0]));
    chk("osc_en", 32'(hot(cfg_clk_src)), 32'(osc_en));
    wb(1'b0, 8'h14, 32'h0, q);
    chk("unmapped", 32'h0, q);
    wb(1'b1, 8'h00, 32'hf02, q, 4'h1);
    wb(1'b0, 8'h00, 32'h0, q);
    chk("lane_mask", 32'h2, q);
    $display("test reset done");
    cur = cfg_clk_src;
    for (int s = 0; s < 6; s++) begin
      wb(1'b1, 8'h04, 32'(s) << 4, q);
      wb(1'b1, 8'h04, 32'h100 | (32'(s) << 4), q);
      if (s < 5) cur = 3'(s);
      wb(1'b0, 8'h04, 32'h0, q);
      chk("switch", 32'(cur), 32'(q[2:0]));
      chk("osc_en", 32'(hot(cur)), 32'(osc_en));
    end
    $display("test switch done");
    h = 8'($urandom);
    wb(1'b1, 8'h0c, 32'(h), q);
    wb(1'b1, 8'h08, 32'h1, q);
    wb(1'b1, 8'h00, 32'h2, q);
    u_cpu.save(1'b0);
    @(posedge clk);
    chk("idle_periph", {24'h0, ~h}, {24'h0, periph_clk_en});
    chk("idle_rc", 32'h1, 32'(low_power_rc_clock));
    chk("idle_clock_failure_monitor", 32'h1, 32'(clock_failure_monitor));
    u_cpu.save(1'b1);
    u_cpu.raise(8'hfe);
    repeat (8) @(posedge clk);
    chk("idle_stays", 32'h1, 32'(sys_clk_en && !cpu_run));
    u_cpu.raise(8'hff);
    wake(n);
    chk("idle_wake", 32'd2, 32'(n));
    chk("vector", 32'h1, 32'(cpu_vector));
    u_cpu.raise(8'h00);
    $display("test idle done");
    wb(1'b1, 8'h00, 32'hf, q);
    repeat (40) @(posedge clk);
    u_cpu.save(1'b1);
    @(posedge clk);
    chk("sleep_rc", 32'h1, 32'(low_power_rc_clock));
    chk("sleep_det", 32'h1, 32'(low_voltage_detector));
    chk("sleep_bor", 32'h1, 32'(brownout_reset));
    chk("sleep_clock_failure_monitor", 32'h0, 32'(clock_failure_monitor));
    wake(n);
    chk("wdt_wake", 32'h1, 32'(n >= WDT - 4 && n <= WDT + 2));
    chk("vector", 32'h0, 32'(cpu_vector));
    wb(1'b0, 8'h10, 32'h0, q);
    chk("stat_wdt", 32'h1, 32'(q[1]));
    n = 0;
    while (wdt_reset_req !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk("wdt_reset", 32'h1, 32'(wdt_reset_req));
    wb(1'b1, 8'h00, 32'h0, q);
    $display("test watchdog done");
    wb(1'b1, 8'h04, 32'h20, q);
    wb(1'b1, 8'h04, 32'h120, q);
    u_cpu.save(1'b1);
    u_cpu.raise(8'h01);
    wake(n);
    chk("xtal_wait", 32'h1, 32'(n >= 4088 && n <= 4110));
    chk("vector", 32'h1, 32'(cpu_vector));
    u_cpu.raise(8'h00);
    $display("test crystal done");
    // Reset in sleep wakes, and an invalid config code falls back
    u_cpu.save(1'b1);
    cfg_clk_src <= 3'h7;
    repeat (4) @(posedge clk);
    chk("sleep_run", 32'h0, 32'(cpu_run));
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("rst_wake", 32'h1, 32'(cpu_run));
    wb(1'b0, 8'h04, 32'h0, q);
    chk("osc_bad_cfg", 32'h0, 32'(q[2:0]));
    chk("osc_en_frc", 32'h1, 32'(osc_en));
    $display("test mid reset done");
    t = 4'($urandom);
    for (int e = 0; e < 2; e++) begin
      wb(1'b1, 8'h00, 32'h4 | (32'(e) << 4) | (32'(t) << 8), q);
      lvd_tap_below <= (e == 1) ? 16'hffff : ~(16'h1 << t);
      external_trip_input <= (e == 0);
      repeat (4) @(posedge clk);
      wb(1'b1, 8'h10, 32'h1, q);
      repeat (4) @(posedge clk);
      chk("lvd_quiet", 32'h0, 32'(lvd_flag));
      lvd_tap_below <= 16'hffff;
      external_trip_input <= 1'b1;
      repeat (4) @(posedge clk);
      chk("lvd_flag", 32'h1, 32'(lvd_flag));
    end
    $display("test low voltage done");
    end_sim();
  end
endmodule : tb_top

`default_nettype wire
